//--- hw/irq_regs_pkg.sv
package irq_regs_pkg;

	// ----------------------------------------
	// special-function register map
	// ----------------------------------------
	localparam logic [7:0] prio_addr      = 8'hB8;
	localparam logic [7:0] ext_en_addr    = 8'hE6;
	localparam logic [7:0] ext_prio_addr  = 8'hF6;
	localparam logic [7:0] prio_page      = 8'h00;
	localparam logic [7:0] prio_reset     = 8'h80;
	localparam logic [7:0] ext_reset      = 8'h00;
	localparam int         prio_fixed_bit = 7;

	// ----------------------------------------
	// source numbering, fixed service order
	// ----------------------------------------
	localparam int num_sources = 15;
	localparam int src_ext0    = 0;
	localparam int src_timer0  = 1;
	localparam int src_ext1    = 2;
	localparam int src_timer1  = 3;
	localparam int src_uart0   = 4;
	localparam int src_timer2  = 5;
	localparam int src_spi0    = 6;
	localparam int src_smbus   = 7;
	localparam int src_alarm   = 8;
	localparam int src_adc_win = 9;
	localparam int src_adc     = 10;
	localparam int src_pca     = 11;
	localparam int src_cmp0    = 12;
	localparam int src_cmp1    = 13;
	localparam int src_timer3  = 14;
	localparam logic [3:0] no_source = 4'hF;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic       wr;
		logic       bit_wr;
		logic [2:0] bit_sel;
		logic       bit_val;
		logic [7:0] addr;
		logic [7:0] page;
		logic [7:0] wdata;
	} sfr_req_type;

	typedef struct packed {
		logic       timer_three_low_overflow;
		logic       timer_three_high_overflow;
		logic       comparator_one_rise_flag;
		logic       comparator_one_fall_flag;
		logic       comparator_zero_rise_flag;
		logic       comparator_zero_fall_flag;
		logic       programmable_counter_array;
		logic       adc_done_flag;
		logic       adc_window_flag;
		logic       clock_alarm;
		logic       smbus_controller;
		logic [6:0] core_pending;
	} pend_type;

	typedef struct packed {
		logic       valid;
		logic       high;
		logic [3:0] source;
	} irq_req_type;

endpackage

//--- hw/irq_pick.sv
`timescale 1ns/1ns
`default_nettype none
// picks lowest-numbered source within a level
module irq_pick (
	input  wire logic [14:0] req_in,
	output logic             any_out,
	output logic [3:0]       idx_out
);
	always_comb begin
		any_out = 1'b0;
		idx_out = irq_regs_pkg::no_source;
		for (int i = irq_regs_pkg::num_sources - 1; i >= 0; i--) begin
			if (req_in[i]) begin
				any_out = 1'b1;
				idx_out = 4'(i);
			end
		end
	end
endmodule
`default_nettype wire

//--- hw/irq_enable_priority_regs.sv
// How it works
// - priority register top bit always reads one; writes to it ignored.
// - priority bit 6 sets serial peripheral zero high when set.
// - priority bit 4 sets uart zero high when set.
// - priority bits 5, 3, 1 set timers two, one, zero high.
// - priority bits 2, 0 set external inputs one, zero high.
// - priority register at 0xB8 page zero, single-bit writable.
// - extended enable bit 7 gates both timer three overflow flags.
// - extended enable bit 6 gates comparator one rise or fall flag.
// - extended enable bit 5 gates comparator zero rise or fall flag.
// - extended enable bit 4 gates all counter array requests.
// - extended enable bit 3 gates adc conversion done flag.
// - extended enable bit 2 gates adc window compare flag.
// - extended enable bit 1 gates clock alarm requests.
// - extended enable bit 0 gates all smbus requests.
// - extended enable register at 0xE6 on every page.
// - extended priority bit 7 sets timer three high.
// - extended priority bits 6, 5 set comparators one, zero high.
// - extended priority bit 4 sets counter array high.
// - extended priority bits 3, 2 set adc done and window high.
// - extended priority bits 1, 0 set clock alarm and smbus high.
// - extended priority register at 0xF6 on every page.
`timescale 1ns/1ns
`default_nettype none
module irq_enable_priority_regs (
	input  wire logic                       clk_in,
	input  wire logic                       reset_in,
	input  wire irq_regs_pkg::sfr_req_type  sfr_req_in,
	input  wire irq_regs_pkg::pend_type     pend_in,
	input  wire logic                       svc_enter_in,
	input  wire logic                       svc_return_in,
	output logic [7:0]                      rdata_out,
	output logic                            rhit_out,
	output logic [7:0]                      primary_irq_priority_out,
	output logic [7:0]                      extended_irq_enable_one_out,
	output logic [7:0]                      extended_irq_priority_one_out,
	output irq_regs_pkg::irq_req_type       irq_req_out
);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic prio_sel;
	logic ext_en_sel;
	logic ext_prio_sel;

	// primary register on page zero only; extended ones on every page
	assign prio_sel     = (sfr_req_in.addr == irq_regs_pkg::prio_addr)
		&& (sfr_req_in.page == irq_regs_pkg::prio_page);
	assign ext_en_sel   = (sfr_req_in.addr == irq_regs_pkg::ext_en_addr);
	assign ext_prio_sel = (sfr_req_in.addr == irq_regs_pkg::ext_prio_addr);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] prio_reg;
	logic [7:0] prio_next;
	logic [7:0] ext_en_reg;
	logic [7:0] ext_en_next;
	logic [7:0] ext_prio_reg;
	logic [7:0] ext_prio_next;

	// byte write or single-bit write of a register
	// a bit write wins over a byte write in the same cycle
	function automatic logic [7:0] apply_write(input logic [7:0] cur,
		input irq_regs_pkg::sfr_req_type r);
		logic [7:0] v;
		v = cur;
		if (r.bit_wr) begin
			v[r.bit_sel] = r.bit_val;
		end else if (r.wr) begin
			v = r.wdata;
		end
		return v;
	endfunction

	// next values; fixed top bit forced
	always_comb begin
		prio_next     = prio_reg;
		ext_en_next   = ext_en_reg;
		ext_prio_next = ext_prio_reg;
		if (prio_sel) begin
			prio_next = apply_write(prio_reg, sfr_req_in);
		end
		if (ext_en_sel) begin
			ext_en_next = apply_write(ext_en_reg, sfr_req_in);
		end
		if (ext_prio_sel) begin
			ext_prio_next = apply_write(ext_prio_reg, sfr_req_in);
		end
		prio_next[irq_regs_pkg::prio_fixed_bit] = 1'b1;
	end

	// primary priority register
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			prio_reg <= irq_regs_pkg::prio_reset;
		end else begin
			prio_reg <= prio_next;
		end
	end

	// extended enable register
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ext_en_reg <= irq_regs_pkg::ext_reset;
		end else begin
			ext_en_reg <= ext_en_next;
		end
	end

	// extended priority register
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ext_prio_reg <= irq_regs_pkg::ext_reset;
		end else begin
			ext_prio_reg <= ext_prio_next;
		end
	end

	// registered copies for the core
	// copies load from the next values, so they track the registers exactly
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			primary_irq_priority_out      <= irq_regs_pkg::prio_reset;
			extended_irq_enable_one_out   <= irq_regs_pkg::ext_reset;
			extended_irq_priority_one_out <= irq_regs_pkg::ext_reset;
		end else begin
			primary_irq_priority_out      <= prio_next;
			extended_irq_enable_one_out   <= ext_en_next;
			extended_irq_priority_one_out <= ext_prio_next;
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_out <= irq_regs_pkg::ext_reset;
			rhit_out  <= 1'b0;
		end else begin
			// a read in a write cycle still sees the old value
			rhit_out <= prio_sel | ext_en_sel | ext_prio_sel;
			if (prio_sel) begin
				rdata_out <= prio_reg;
			end else if (ext_en_sel) begin
				rdata_out <= ext_en_reg;
			end else if (ext_prio_sel) begin
				rdata_out <= ext_prio_reg;
			end else begin
				rdata_out <= irq_regs_pkg::ext_reset;
			end
		end
	end

	// ----------------------------------------
	// gating and level per source
	// ----------------------------------------
	// extended bit j serves source src_smbus + j, so positions follow the source numbers
	localparam int ext_base    = irq_regs_pkg::src_smbus;
	localparam int pos_timer3  = irq_regs_pkg::src_timer3 - ext_base;
	localparam int pos_cmp1    = irq_regs_pkg::src_cmp1 - ext_base;
	localparam int pos_cmp0    = irq_regs_pkg::src_cmp0 - ext_base;
	localparam int pos_pca     = irq_regs_pkg::src_pca - ext_base;
	localparam int pos_adc     = irq_regs_pkg::src_adc - ext_base;
	localparam int pos_adc_win = irq_regs_pkg::src_adc_win - ext_base;
	localparam int pos_alarm   = irq_regs_pkg::src_alarm - ext_base;
	localparam int pos_smbus   = irq_regs_pkg::src_smbus - ext_base;

	logic [14:0] gated;
	logic [14:0] level;

	// the seven core sources arrive already masked by the global enable
	assign gated[6:0] = pend_in.core_pending;
	// two-flag sources raise one request; the enable bit masks both flags
	assign gated[irq_regs_pkg::src_timer3] = ext_en_reg[pos_timer3] &
		(pend_in.timer_three_low_overflow | pend_in.timer_three_high_overflow);
	assign gated[irq_regs_pkg::src_cmp1] = ext_en_reg[pos_cmp1] &
		(pend_in.comparator_one_rise_flag | pend_in.comparator_one_fall_flag);
	assign gated[irq_regs_pkg::src_cmp0] = ext_en_reg[pos_cmp0] &
		(pend_in.comparator_zero_rise_flag | pend_in.comparator_zero_fall_flag);
	// single-flag sources pass straight through their enable bit
	assign gated[irq_regs_pkg::src_pca] = ext_en_reg[pos_pca] & pend_in.programmable_counter_array;
	assign gated[irq_regs_pkg::src_adc] = ext_en_reg[pos_adc] & pend_in.adc_done_flag;
	assign gated[irq_regs_pkg::src_adc_win] = ext_en_reg[pos_adc_win] & pend_in.adc_window_flag;
	assign gated[irq_regs_pkg::src_alarm] = ext_en_reg[pos_alarm] & pend_in.clock_alarm;
	assign gated[irq_regs_pkg::src_smbus] = ext_en_reg[pos_smbus] & pend_in.smbus_controller;

	// primary priority bits map onto sources 0..6 bit for bit
	// so a core source's number is also its bit position
	assign level[irq_regs_pkg::src_spi0]   = prio_reg[irq_regs_pkg::src_spi0];
	assign level[irq_regs_pkg::src_uart0]  = prio_reg[irq_regs_pkg::src_uart0];
	assign level[irq_regs_pkg::src_timer2] = prio_reg[irq_regs_pkg::src_timer2];
	assign level[irq_regs_pkg::src_timer1] = prio_reg[irq_regs_pkg::src_timer1];
	assign level[irq_regs_pkg::src_timer0] = prio_reg[irq_regs_pkg::src_timer0];
	assign level[irq_regs_pkg::src_ext1]   = prio_reg[irq_regs_pkg::src_ext1];
	assign level[irq_regs_pkg::src_ext0]   = prio_reg[irq_regs_pkg::src_ext0];
	// extended priority bits 0..7 map onto sources 7..14
	// each level bit picks the arbiter that the source joins
	assign level[irq_regs_pkg::src_timer3] = ext_prio_reg[pos_timer3];
	assign level[irq_regs_pkg::src_cmp1]   = ext_prio_reg[pos_cmp1];
	assign level[irq_regs_pkg::src_cmp0]   = ext_prio_reg[pos_cmp0];
	assign level[irq_regs_pkg::src_pca]    = ext_prio_reg[pos_pca];
	assign level[irq_regs_pkg::src_adc]    = ext_prio_reg[pos_adc];
	assign level[irq_regs_pkg::src_adc_win] = ext_prio_reg[pos_adc_win];
	assign level[irq_regs_pkg::src_alarm]  = ext_prio_reg[pos_alarm];
	assign level[irq_regs_pkg::src_smbus]  = ext_prio_reg[pos_smbus];

	// ----------------------------------------
	// service state and arbitration
	// ----------------------------------------
	// both means a high service nested inside a low one
	typedef enum logic [1:0] {
		svc_idle = 2'b00,
		svc_low  = 2'b01,
		svc_high = 2'b10,
		svc_both = 2'b11
	} svc_state_type;

	svc_state_type svc_reg;
	svc_state_type svc_next;
	logic          high_any;
	logic          low_any;
	logic [3:0]    high_idx;
	logic [3:0]    low_idx;
	logic          take_high;
	logic          take_low;

	irq_pick high_pick (
		.req_in  (gated & level),
		.any_out (high_any),
		.idx_out (high_idx)
	);

	irq_pick low_pick (
		.req_in  (gated & ~level),
		.any_out (low_any),
		.idx_out (low_idx)
	);

	// high may interrupt low service; low only from idle
	// a second low level cannot nest, so the core never stacks two low services
	assign take_high = high_any & ((svc_reg == svc_idle) | (svc_reg == svc_low));
	assign take_low  = low_any & ~high_any & (svc_reg == svc_idle);

	// nesting of service levels
	// enter only moves the state when a request was on offer
	always_comb begin
		svc_next = svc_reg;
		unique case (svc_reg)
			svc_idle: begin
				if (svc_enter_in & take_high) begin
					svc_next = svc_high;
				end else if (svc_enter_in & take_low) begin
					svc_next = svc_low;
				end
			end
			svc_low: begin
				if (svc_enter_in & take_high) begin
					svc_next = svc_both;
				end else if (svc_return_in) begin
					svc_next = svc_idle;
				end
			end
			svc_high: begin
				if (svc_return_in) begin
					svc_next = svc_idle;
				end
			end
			svc_both: begin
				if (svc_return_in) begin
					svc_next = svc_low;
				end
			end
		endcase
	end

	// service level tracker
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			svc_reg <= svc_idle;
		end else begin
			svc_reg <= svc_next;
		end
	end

	// registered request to the core
	// the core samples a settled flop, never the arbiter's decode
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			irq_req_out <= '{valid: 1'b0, high: 1'b0, source: irq_regs_pkg::no_source};
		end else if (take_high) begin
			irq_req_out <= '{valid: 1'b1, high: 1'b1, source: high_idx};
		end else if (take_low) begin
			irq_req_out <= '{valid: 1'b1, high: 1'b0, source: low_idx};
		end else begin
			irq_req_out <= '{valid: 1'b0, high: 1'b0, source: irq_regs_pkg::no_source};
		end
	end

endmodule
`default_nettype wire

//--- tb/irq_regs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module irq_regs_assertions (
	input wire logic                      clk_in,
	input wire logic                      reset_in,
	input wire irq_regs_pkg::sfr_req_type sfr_req_in,
	input wire irq_regs_pkg::pend_type    pend_in,
	input wire logic                      svc_enter_in,
	input wire logic                      svc_return_in,
	input wire logic [7:0]                rdata_out,
	input wire logic                      rhit_out,
	input wire logic [7:0]                primary_irq_priority_out,
	input wire logic [7:0]                extended_irq_enable_one_out,
	input wire logic [7:0]                extended_irq_priority_one_out,
	input wire irq_regs_pkg::irq_req_type irq_req_out
);
	// ----------------
	// register checks
	// ----------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// byte write and address decode
	wire logic bw = sfr_req_in.wr && !sfr_req_in.bit_wr;
	wire logic a0 = sfr_req_in.addr == 8'hB8 && sfr_req_in.page == 8'h00;
	wire logic hit = a0 || sfr_req_in.addr == 8'hE6 || sfr_req_in.addr == 8'hF6;
	sequence s_miss;
		!hit;
	endsequence
	sequence s_blank;
		!rhit_out && rdata_out == 8'h00;
	endsequence
	chk_prio_top_one: assert property (primary_irq_priority_out[7])
		else $error("priority top bit low");
	chk_prio_write: assert property (bw && a0 |=>
		primary_irq_priority_out == ($past(sfr_req_in.wdata) | 8'h80)) else $error("priority write lost");
	chk_prio_page: assert property (bw && sfr_req_in.addr == 8'hB8 && !a0 |=>
		$stable(primary_irq_priority_out)) else $error("priority written off page");
	chk_en_write: assert property (bw && sfr_req_in.addr == 8'hE6 |=>
		extended_irq_enable_one_out == $past(sfr_req_in.wdata)) else $error("enable write lost");
	chk_eprio_write: assert property (bw && sfr_req_in.addr == 8'hF6 |=>
		extended_irq_priority_one_out == $past(sfr_req_in.wdata)) else $error("ext prio write lost");
	chk_read_hit: assert property (hit |=> rhit_out) else $error("read hit missing");
	chk_read_miss: assert property (s_miss |=> s_blank) else $error("unmapped read not blank");
	chk_adc_gate: assert property (irq_req_out.valid && irq_req_out.source == 4'hA |->
		$past(extended_irq_enable_one_out[3]) && $past(pend_in.adc_done_flag)) else $error("adc gate");
	chk_t3_level: assert property (irq_req_out.valid && irq_req_out.source == 4'hE |->
		$past(extended_irq_enable_one_out[7]) && irq_req_out.high == $past(extended_irq_priority_one_out[7]))
		else $error("timer three level");
	chk_none_src: assert property (!irq_req_out.valid |-> irq_req_out.source == 4'hF)
		else $error("idle source");
endmodule
bind irq_enable_priority_regs irq_regs_assertions u_chk (.clk_in(clk_in), .reset_in(reset_in),
	.sfr_req_in(sfr_req_in), .pend_in(pend_in), .svc_enter_in(svc_enter_in), .svc_return_in(svc_return_in),
	.rdata_out(rdata_out), .rhit_out(rhit_out), .primary_irq_priority_out(primary_irq_priority_out),
	.extended_irq_enable_one_out(extended_irq_enable_one_out),
	.extended_irq_priority_one_out(extended_irq_priority_one_out), .irq_req_out(irq_req_out));
`default_nettype wire

//--- tb/core_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_model (
	input wire logic clk_in,
	output logic     enter_out,
	output logic     leave_out
);
	// ----------------
	// service pulses
	// ----------------
	initial begin
		enter_out = 1'b0;
		leave_out = 1'b0;
	end
	// vector after gap plus one cycles, one-cycle pulse
	task automatic vector(input int gap);
		repeat (gap) @(negedge clk_in);
		@(negedge clk_in);
		enter_out = 1'b1;
		@(negedge clk_in);
		enter_out = 1'b0;
	endtask
	// return from service, one-cycle pulse
	task automatic leave();
		@(negedge clk_in);
		leave_out = 1'b1;
		@(negedge clk_in);
		leave_out = 1'b0;
	endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	// ----------------
	// bench state
	// ----------------
	logic                      clk_in = 1'b0;
	logic                      reset_in = 1'b1;
	irq_regs_pkg::sfr_req_type req = '0;
	irq_regs_pkg::pend_type    pend = '0;
	irq_regs_pkg::irq_req_type irq;
	logic                      ent, lv, rhit, rd = 1'b0, rd_q = 1'b0;
	logic [7:0]                rdata, pr, en, ep, d, pv, ev;
	logic [8:0]                expq[$];
	logic [31:0]               seed = 32'h0001_62B7;
	int                        mismatches = 0, n_tests = 0, b, pos;
	always #20 clk_in = ~clk_in;
	core_model core (.clk_in(clk_in), .enter_out(ent), .leave_out(lv));
	irq_enable_priority_regs DUT (.clk_in(clk_in), .reset_in(reset_in), .sfr_req_in(req), .pend_in(pend),
		.svc_enter_in(ent), .svc_return_in(lv), .rdata_out(rdata), .rhit_out(rhit),
		.primary_irq_priority_out(pr), .extended_irq_enable_one_out(en),
		.extended_irq_priority_one_out(ep), .irq_req_out(irq));
	// xorshift source
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// compare and count
	task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results();
		$display("mismatches %0d comparisons %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// byte write, or bit write with d[2:0] select and d[3] value
	task automatic put(input logic bit_op, input logic [7:0] a, input logic [7:0] p, input logic [7:0] dv);
		@(negedge clk_in);
		req = '{wr: !bit_op, bit_wr: bit_op, bit_sel: dv[2:0], bit_val: dv[3], addr: a, page: p, wdata: dv};
		@(negedge clk_in);
		req.wr = 1'b0;
		req.bit_wr = 1'b0;
	endtask
	// read request, expected {hit, data} noted
	task automatic rdx(input logic [7:0] a, input logic [7:0] p, input logic [8:0] e);
		@(negedge clk_in);
		req.addr = a;
		req.page = p;
		rd = 1'b1;
		expq.push_back(e);
		@(negedge clk_in);
		rd = 1'b0;
	endtask
	task automatic irqx(input logic [5:0] e);
		repeat (2) @(negedge clk_in);
		check("irq_req", 9'(irq), 9'(e));
	endtask
	// read monitor: oldest note against registered answer
	always @(posedge clk_in) rd_q <= rd;
	always @(negedge clk_in) begin
		if (rd_q)
			check("read", {rhit, rdata}, expq.pop_front());
	end
	initial begin
		#400000;
		mismatches++;
		results();
	end
	// main sequence
	initial begin
		repeat (4) @(negedge clk_in);
		reset_in = 1'b0;
		rdx(8'hB8, 8'h00, 9'h180);
		rdx(8'hE6, 8'h21, 9'h100);
		rdx(8'hF6, 8'h44, 9'h100);
		rdx(8'h55, 8'h00, 9'h000);
		d = 8'(xs());
		put(1'b0, 8'hB8, 8'h00, d);
		put(1'b0, 8'hB8, 8'h01, ~d);
		rdx(8'hB8, 8'h01, 9'h000);
		rdx(8'hB8, 8'h00, {1'b1, d | 8'h80});
		put(1'b0, 8'hE6, 8'h03, d);
		put(1'b0, 8'hF6, 8'h05, ~d);
		rdx(8'hE6, 8'h07, {1'b1, d});
		rdx(8'hF6, 8'h09, {1'b1, ~d});
		check("ext_en", {1'b0, en}, {1'b0, d});
		check("ext_prio", {1'b0, ep}, {1'b0, ~d});
		put(1'b0, 8'hB8, 8'h00, 8'h00);
		for (int i = 0; i < 8; i++) begin
			put(1'b1, 8'hB8, 8'h00, {4'h0, i < 7, 3'(i)});
			check("prio", {1'b0, pr}, {1'b0, 8'((1 << (i + 1)) - 1) | 8'h80});
		end
		pv = 8'(xs());
		ev = 8'(xs());
		put(1'b0, 8'hB8, 8'h00, pv);
		put(1'b0, 8'hF6, 8'h00, ev);
		put(1'b0, 8'hE6, 8'h00, 8'h00);
		for (int k = 0; k < 15; k++) begin
			b = k - 7;
			pos = k < 7 ? k : (b < 5 ? 7 + b : 2 * b + 2 + int'(xs() & 1));
			pend = irq_regs_pkg::pend_type'(18'h0_0001 << pos);
			if (k > 6) begin
				irqx(6'h0F);
				put(1'b0, 8'hE6, 8'h00, 8'h01 << b);
			end
			irqx({1'b1, k < 7 ? pv[k] : ev[b], 4'(k)});
			pend = '0;
			@(negedge clk_in);
		end
		put(1'b0, 8'hE6, 8'h00, 8'h03);
		put(1'b0, 8'hF6, 8'h00, 8'h00);
		pend = irq_regs_pkg::pend_type'(18'h0_0180);
		irqx(6'h27);
		core.vector(1);
		irqx(6'h0F);
		put(1'b0, 8'hF6, 8'h00, 8'h02);
		irqx(6'h38);
		core.vector(0);
		core.leave();
		core.leave();
		irqx(6'h38);
		core.vector(0);
		irqx(6'h0F);
		core.leave();
		put(1'b0, 8'hF6, 8'h00, 8'h00);
		irqx(6'h27);
		@(negedge clk_in);
		reset_in = 1'b1;
		repeat (2) @(negedge clk_in);
		reset_in = 1'b0;
		rdx(8'hE6, 8'h00, 9'h100);
		check("prio_rst", {1'b0, pr}, 9'h080);
		repeat (2) @(negedge clk_in);
		check("read_queue", 9'(expq.size()), 9'h000);
		results();
	end
endmodule
`default_nettype wire
